// File: shared/nor_host_pkg.sv
// Purpose: constants shared by the flash bus controller and its page buffer
// Assumes: ref_clk at 20 MHz; APB byte offsets, one word per register
// Notes: least times round up to whole cycles
package nor_host_pkg;
  localparam int CLK_NS = 50;
  localparam int T_RD_ACC_NS = 110;
  localparam int T_PAGE_NS = 25;
  localparam int T_WE_PULSE_NS = 70;
  localparam int T_GAP_NS = 30;

  function automatic logic [3:0] ns_to_cyc(input int ns);
    return 4'((ns + CLK_NS - 1) / CLK_NS);
  endfunction : ns_to_cyc

  localparam logic [3:0] RD_CYC = ns_to_cyc(T_RD_ACC_NS);
  localparam logic [3:0] PAGE_CYC = ns_to_cyc(T_PAGE_NS);
  localparam logic [3:0] WE_CYC = ns_to_cyc(T_WE_PULSE_NS);
  localparam logic [3:0] GAP_CYC = ns_to_cyc(T_GAP_NS);

  localparam int ADDR_W = 27;
  localparam int BLK_SHIFT = 16;
  localparam int BLK_LOG2_MIN = 8;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] PAGE_BASE = 8'h40;
  localparam logic [7:0] PAGE_END = 8'h7C;

  localparam int CTRL_GO = 2;
  localparam int CTRL_BYTE = 3;
  localparam int CTRL_EXT = 4;
  localparam int CTRL_WP = 5;
  localparam int CTRL_RST = 6;
  localparam int CTRL_DENS = 7;
  localparam logic [8:0] CTRL_RESET = 9'h060;

  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT = 5;
  localparam int ERASE_TIMER_BIT = 3;
  localparam int ALT_TOGGLE_BIT = 2;
  localparam int BUFFER_ABORT_BIT = 1;
  localparam logic [7:0] READ_RESET_CMD = 8'hF0;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_PAGE, OP_POLL} op_t;
  typedef enum logic [2:0] {S_IDLE, S_RD, S_WR_SET, S_WR_LOW, S_WR_HOLD, S_GAP} state_t;
endpackage : nor_host_pkg

// File: core/nor_page_mem.sv
// Purpose: 16-word page buffer with byte lanes and registered read data
// Assumes: one write and one read port, both on ref_clk
// Notes: read data appears one edge after rd_idx
`timescale 1ns/100ps
module nor_page_mem
  import nor_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data
);
  typedef struct packed {
    logic [15:0][15:0] mem;
    logic [15:0] rd;
  } mem_t;

  mem_t s_reg;
  mem_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (wr_en)
    begin
      if (wr_be[0])
        s_next.mem[wr_idx][7:0] = wr_data[7:0];
      if (wr_be[1])
        s_next.mem[wr_idx][15:8] = wr_data[15:8];
    end
    s_next.rd = s_reg.mem[rd_idx];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign rd_data = s_reg.rd;
endmodule : nor_page_mem

// File: core/nor_host_ctrl.sv
// Purpose: APB-driven host controller for an asynchronous parallel NOR flash bus
// Assumes: flash inputs synchronous to ref_clk; software orders ops via CTRL go bit
// Notes: one op at a time; CTRL writes while busy are refused
// Behaviour
// [RULE1] array is uniform 128KB blocks, 64K words each
// [RULE2] block count 256, 512, 1024 or 2048 by density
// [RULE3] read: address out, chip select and output enable low, write enable high
// [RULE4] address taken at later falling edge, data at earlier rising edge
// [RULE5] output enable stays high through every write
// [RULE6] page of 16 words or 32 bytes, picked by low address bits
// [RULE7] extended blocks and query area use single random reads only
// [RULE8] chip select high or output enable high floats device data lines
// [RULE9] reset pin low deselects device and floats its outputs
// [RULE10] pulses under about 3ns on strobes and reset are ignored
// [RULE11] write-protect low keeps highest or lowest block protected
// [RULE12] poll bit inverts program data, reads 0 in erase, true on success
// [RULE13] erase suspend: poll bit 0 in erasing blocks until suspended, then 1
// [RULE14] toggle bit inverts on every read while program or erase runs
// [RULE15] in suspend, toggle bit toggles in erased block until really suspended
// [RULE16] error bit 1 when program, erase or blank check fails
// [RULE17] after error bit, host sends read/reset before further commands
// [RULE18] erase timer bit 0 before erase starts, 1 once under way
// [RULE19] alternative toggle bit inverts on reads inside blocks being erased
// [RULE20] abort bit marks aborted buffered program; host sends abort-reset command
// [RULE21] status on low eight data lines during program, erase, suspend
// [RULE22] in suspend, other blocks read as normal array data
// [RULE23] byte mode: lines 14..8 unused, top data pin is lowest address bit
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module nor_host_ctrl
  import nor_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic flash_rst_n,
  output logic wp_n,
  output logic byte_n,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe
);
  typedef struct packed {
    state_t st;
    logic [3:0] cnt;
    logic [4:0] idx;
    logic ce_n, oe_n, we_n;
    logic [ADDR_W-1:0] fa;
    logic [15:0] dqo, dqoe;
    logic [8:0] ctrl;
    logic [27:0] addr;
    logic [15:0] wdata, rdata;
    logic [7:0] stat, prev;
    logic first, err_pend, fin;
    logic busy, error_seen, abort_seen, lock, refused, erase_timer, alt_toggled, poll_ok;
    logic ack, pg, err;
    logic [31:0] prdata;
  } ctl_t;

  ctl_t s;
  ctl_t n;
  logic mem_we;
  logic [3:0] mem_idx;
  logic [1:0] mem_be;
  logic [15:0] mem_wd;
  logic [15:0] mem_rd;

  // word address plus the byte-mode lowest address bit
  function automatic logic [ADDR_W:0] bus_addr(input logic [27:0] a, input logic [4:0] idx,
                                               input logic bm);
    return {a[26:4], (bm ? idx[4:1] : idx[3:0]), idx[0]};
  endfunction : bus_addr

  function automatic logic block_ok(input logic [27:0] a, input logic [1:0] dens);
    return (a[26:BLK_SHIFT] >> (BLK_LOG2_MIN + int'(dens))) == 11'h000;
  endfunction : block_ok

  always_comb
  begin
    op_t op;
    logic bm;
    logic lo;
    logic [7:0] st8;
    logic page_hit;
    op = op_t'(s.ctrl[1:0]);
    bm = s.ctrl[CTRL_BYTE];
    lo = 1'b0;
    st8 = dq_in[7:0]; // [RULE21]
    page_hit = paddr >= PAGE_BASE && paddr <= PAGE_END && paddr[1:0] == 2'b00;
    n = s;
    n.ack = psel && penable && !s.ack;
    if (psel && penable && !s.ack)
    begin
      n.pg = 1'b0;
      n.err = 1'b0;
      if (paddr == OFF_CTRL)
        n.prdata = {23'h000000, s.ctrl};
      else if (paddr == OFF_ADDR)
        n.prdata = {4'h0, s.addr};
      else if (paddr == OFF_WDATA)
        n.prdata = {16'h0000, s.wdata};
      else if (paddr == OFF_STATUS)
        n.prdata = {16'h0000, s.stat, s.poll_ok, s.alt_toggled, s.erase_timer, s.refused,
                    s.lock, s.abort_seen, s.error_seen, s.busy};
      else if (paddr == OFF_RDATA)
        n.prdata = {16'h0000, s.rdata};
      else if (page_hit && !pwrite)
        n.pg = 1'b1;
      else
        n.err = 1'b1;
      if (pwrite && (paddr == OFF_STATUS || paddr == OFF_RDATA))
        n.err = 1'b1;
    end
    if (pready && pwrite && !s.err)
    begin
      if (paddr == OFF_ADDR)
        n.addr = pwdata[27:0];
      else if (paddr == OFF_WDATA)
        n.wdata = pwdata[15:0];
      else if (paddr == OFF_CTRL && s.busy)
        n.refused = 1'b1;
      else if (paddr == OFF_CTRL)
      begin
        n.ctrl = pwdata[8:0];
        n.ctrl[CTRL_GO] = 1'b0;
        if (!pwdata[CTRL_RST])
          n.lock = 1'b0;
        if (pwdata[CTRL_GO])
        begin
          n.refused = !pwdata[CTRL_RST] // [RULE9]
            || !block_ok(s.addr, pwdata[CTRL_DENS+:2]) // [RULE1] [RULE2]
            || (s.lock && op_t'(pwdata[1:0]) == OP_WRITE
                && s.wdata[7:0] != READ_RESET_CMD); // [RULE17] [RULE20]
          if (!n.refused)
          begin
            n.busy = 1'b1;
            n.fin = 1'b0;
            n.first = 1'b1;
            n.err_pend = 1'b0;
            n.error_seen = 1'b0;
            n.abort_seen = 1'b0;
            n.alt_toggled = 1'b0;
            n.poll_ok = 1'b0;
            n.ce_n = 1'b0;
            n.idx = pwdata[CTRL_BYTE] ? {s.addr[3:0], s.addr[27]} : {1'b0, s.addr[3:0]};
            if (op_t'(pwdata[1:0]) == OP_PAGE)
              n.idx = 5'h00; // [RULE6]
            if (op_t'(pwdata[1:0]) == OP_WRITE)
              n.st = S_WR_SET;
            else
            begin
              n.st = S_RD;
              n.oe_n = 1'b0; // [RULE3]
              n.cnt = RD_CYC;
            end
          end
        end
      end
    end
    case (s.st)
      S_RD:
      begin
        n.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h1)
        begin
          n.rdata = bm ? {8'h00, dq_in[7:0]} : dq_in;
          if (op == OP_PAGE && s.idx != (bm ? 5'h1F : 5'h0F))
          begin
            n.idx = s.idx + 5'h01;
            n.cnt = s.ctrl[CTRL_EXT] ? RD_CYC : PAGE_CYC; // [RULE6] [RULE7]
          end
          else
          begin
            // every poll is a full strobe cycle so the toggle bits advance
            n.ce_n = 1'b1; // [RULE8]
            n.oe_n = 1'b1;
            n.st = S_GAP;
            n.cnt = GAP_CYC;
            n.fin = op != OP_POLL;
          end
          if (op == OP_POLL)
          begin
            n.stat = st8;
            n.prev = st8;
            n.first = 1'b0;
            n.erase_timer = st8[ERASE_TIMER_BIT]; // [RULE18]
            if (!s.first)
            begin
              n.alt_toggled = s.alt_toggled
                || st8[ALT_TOGGLE_BIT] != s.prev[ALT_TOGGLE_BIT]; // [RULE19]
              if (st8[TOGGLE_BIT] == s.prev[TOGGLE_BIT]) // [RULE14] [RULE15]
              begin
                n.fin = 1'b1;
                n.poll_ok = st8[POLL_BIT] == s.wdata[7]; // [RULE12] [RULE13]
              end
              else if (s.err_pend)
              begin
                // still toggling after a flagged failure: the operation is dead
                n.fin = 1'b1;
                n.error_seen = st8[ERROR_BIT]; // [RULE16]
                n.abort_seen = st8[BUFFER_ABORT_BIT]; // [RULE20]
                n.lock = 1'b1; // [RULE17]
              end
              else
                n.err_pend = st8[ERROR_BIT] || st8[BUFFER_ABORT_BIT];
            end
          end
        end
      end
      S_WR_SET:
      begin
        n.we_n = 1'b0; // [RULE4]
        n.cnt = WE_CYC;
        n.st = S_WR_LOW;
      end
      S_WR_LOW:
      begin
        n.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h1)
        begin
          n.we_n = 1'b1; // [RULE10]
          n.st = S_WR_HOLD;
        end
      end
      S_WR_HOLD:
      begin
        n.ce_n = 1'b1; // [RULE4]
        n.st = S_GAP;
        n.cnt = GAP_CYC;
        n.fin = 1'b1;
        if (s.wdata[7:0] == READ_RESET_CMD)
          n.lock = 1'b0; // [RULE17] [RULE20]
      end
      S_GAP:
      begin
        n.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h1 && s.fin)
        begin
          n.st = S_IDLE;
          n.busy = 1'b0;
        end
        else if (s.cnt == 4'h1)
        begin
          n.st = S_RD;
          n.ce_n = 1'b0;
          n.oe_n = 1'b0;
          n.cnt = RD_CYC;
        end
      end
      default:
      begin
        n.cnt = 4'h0;
      end
    endcase
    {n.fa, lo} = bus_addr(n.addr, n.idx, n.ctrl[CTRL_BYTE]);
    n.dqo = 16'h0000;
    n.dqoe = 16'h0000;
    if (!n.ce_n)
    begin
      if (n.ctrl[CTRL_BYTE])
      begin
        n.dqoe[15] = 1'b1; // [RULE23]
        n.dqo[15] = lo;
      end
      if (n.st == S_WR_SET || n.st == S_WR_LOW || n.st == S_WR_HOLD)
      begin
        n.dqoe[7:0] = 8'hFF;
        n.dqo[7:0] = n.wdata[7:0];
        if (!n.ctrl[CTRL_BYTE])
        begin
          n.dqoe[15:8] = 8'hFF;
          n.dqo[15:8] = n.wdata[15:8];
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.ce_n <= 1'b1;
      s.oe_n <= 1'b1;
      s.we_n <= 1'b1;
      s.ctrl <= CTRL_RESET;
    end
    else
      s <= n;
  end

  assign mem_we = s.st == S_RD && s.cnt == 4'h1 && op_t'(s.ctrl[1:0]) == OP_PAGE;
  assign mem_idx = s.ctrl[CTRL_BYTE] ? s.idx[4:1] : s.idx[3:0];
  assign mem_be = !s.ctrl[CTRL_BYTE] ? 2'b11 : (s.idx[0] ? 2'b10 : 2'b01);
  assign mem_wd = s.ctrl[CTRL_BYTE] ? {dq_in[7:0], dq_in[7:0]} : dq_in;

  nor_page_mem page_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(mem_we),
    .wr_idx(mem_idx),
    .wr_be(mem_be),
    .wr_data(mem_wd),
    .rd_idx(paddr[5:2]),
    .rd_data(mem_rd)
  );

  assign pready = psel && penable && s.ack;
  assign pslverr = pready && s.err;
  assign prdata = s.pg ? {16'h0000, mem_rd} : s.prdata;
  assign ce_n = s.ce_n;
  assign oe_n = s.oe_n;
  assign we_n = s.we_n;
  assign flash_addr = s.fa;
  assign dq_out = s.dqo;
  assign dq_oe = s.dqoe;
  assign flash_rst_n = s.ctrl[CTRL_RST];
  assign wp_n = s.ctrl[CTRL_WP]; // [RULE11]
  assign byte_n = !s.ctrl[CTRL_BYTE];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence we_pulse_s;
    !we_n [*2] ##1 we_n;
  endsequence
  sequence wr_close_s;
    we_n && !ce_n && dq_oe[7:0] == 8'hFF ##1 ce_n;
  endsequence
  sequence rd_hold_s;
    (!oe_n && !ce_n && we_n) [*3];
  endsequence

  wr_oe_high_a: assert property (!we_n |-> oe_n) // [RULE5]
    else $error("output enable low during a write");
  rd_pin_state_a: assert property (!oe_n |-> !ce_n && we_n && dq_oe[7:0] == 8'h00) // [RULE3]
    else $error("bad pin state while reading");
  rd_access_a: assert property ($fell(oe_n) |-> rd_hold_s) // [RULE3]
    else $error("read strobe shorter than access time");
  we_pulse_a: assert property ($fell(we_n) |-> we_pulse_s) // [RULE10]
    else $error("write strobe width wrong");
  wr_addr_latch_a: assert property ($fell(we_n) |-> !ce_n && $stable(flash_addr)
    && dq_oe[7:0] == 8'hFF) // [RULE4]
    else $error("address or data not ready at write strobe fall");
  wr_data_hold_a: assert property ($rose(we_n) |-> wr_close_s) // [RULE4]
    else $error("data not held at write strobe rise");
  byte_lanes_a: assert property (!byte_n && !ce_n |-> dq_oe[14:8] == 7'h00
    && dq_oe[15]) // [RULE23]
    else $error("byte mode lane use wrong");
  rst_deselect_a: assert property (!flash_rst_n |-> ce_n) // [RULE9]
    else $error("device selected while held in reset");
  lock_refuse_a: assert property (pready && pwrite && paddr == OFF_CTRL && !s.busy
    && pwdata[CTRL_GO] && pwdata[CTRL_RST] && pwdata[1:0] == 2'b01 && s.lock
    && s.wdata[7:0] != READ_RESET_CMD |=> s.refused && s.st == S_IDLE) // [RULE17]
    else $error("command accepted while error lock set");
  fail_lock_a: assert property ($rose(s.abort_seen) || $rose(s.error_seen) |-> s.lock) // [RULE20]
    else $error("failure seen without lock");
  status_byte_a: assert property (s.st == S_RD && s.cnt == 4'h1 && s.ctrl[1:0] == 2'b11
    |=> s.stat == $past(dq_in[7:0])) // [RULE21]
    else $error("status byte not captured");
endmodule : nor_host_ctrl

// File: bench/flash_model.sv
// Purpose: behavioural flash device facing the host controller
// Assumes: a write other than F0, while idle and error-free, programs one word, busy for three reads
// Notes: fail ends the program with the error bit set and toggling kept up
`timescale 1ns/100ps
module flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  input wire logic byte_n,
  input wire logic fail,
  input wire logic [26:0] addr,
  input wire logic [15:0] dq_host,
  output logic [15:0] dq_dev,
  output logic [15:0] dev_en
);
  logic [15:0] mem [0:63];
  logic [15:0] wd;
  logic [15:0] word;
  logic [5:0] wa;
  logic [1:0] left;
  logic tog;
  logic err;
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = 16'hA500 + 16'(i);
    left = 2'h0;
    tog = 1'b0;
    err = 1'b0;
  end
  // address at the later fall of the two strobes
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n)
      wa = addr[5:0];
  // data at the earlier rise: only one strobe is high then
  always @(posedge we_n or posedge ce_n)
    if (rst_n && (we_n ^ ce_n))
    begin
      wd = dq_host;
      if (wd[7:0] == 8'hF0)
      begin
        left = 2'h0;
        err = 1'b0;
      end
      else if (left == 2'h0 && !err)
        left = 2'h3;
    end
  always @(negedge oe_n)
    if (rst_n && !ce_n && (left != 2'h0 || err))
    begin
      tog = ~tog;
      if (left != 2'h0)
      begin
        left = left - 2'h1;
        if (left == 2'h0 && fail)
          err = 1'b1;
        else if (left == 2'h0)
          mem[wa] = wd;
      end
    end
  always @(negedge rst_n)
  begin
    left = 2'h0;
    err = 1'b0;
  end
  assign word = (left != 2'h0 || err) ? {8'h00, ~wd[7], tog, err, 5'h00} : mem[addr[5:0]];
  assign dq_dev = byte_n ? word : {8'h00, dq_host[15] ? word[15:8] : word[7:0]};
  assign dev_en = (rst_n && !ce_n && !oe_n) ? (byte_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
endmodule : flash_model

// File: bench/tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: APB master with sampling of pready on the falling edge before it counts
// Notes: released data lines show the inverse of their last level
`timescale 1ns/100ps
module tb
  import nor_host_pkg::*;
();
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fail = 1'b0;
  logic clash = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, ce_n, oe_n, we_n, flash_rst_n, wp_n, byte_n;
  logic [26:0] flash_addr;
  logic [15:0] dq_out, dq_oe, dq_dev, dev_en, dq_bus;
  logic [15:0] dq_last = 16'h0;
  int error_cnt = 0;
  int n_tests = 0;
  nor_host_ctrl dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .flash_rst_n(flash_rst_n),
    .wp_n(wp_n), .byte_n(byte_n), .flash_addr(flash_addr), .dq_in(dq_bus), .dq_out(dq_out),
    .dq_oe(dq_oe));
  flash_model model_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(flash_rst_n),
    .byte_n(byte_n), .fail(fail), .addr(flash_addr), .dq_host(dq_bus), .dq_dev(dq_dev),
    .dev_en(dev_en));
  assign dq_bus = (dq_oe & dq_out) | (~dq_oe & dev_en & dq_dev) | (~dq_oe & ~dev_en & ~dq_last);
  always @(posedge ref_clk)
  begin
    dq_last <= dq_bus;
    if (!sys_rst && !oe_n && !we_n)
      clash <= 1'b1;
  end
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    complete_run;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // status ends up in rd once busy has dropped
  task automatic op(input logic [31:0] a, input logic [31:0] wdv, input logic [31:0] ctrl);
    int n;
    n = 0;
    apb(1'b1, OFF_ADDR, a);
    apb(1'b1, OFF_WDATA, wdv);
    apb(1'b1, OFF_CTRL, ctrl);
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 200);
  endtask : op
  task automatic t_reset;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl", rd, {23'h0, CTRL_RESET});
    chk("pins", {ce_n, oe_n, we_n, flash_rst_n, wp_n, byte_n, dq_oe}, {6'h3F, 16'h0});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", er, 32'h1);
    apb(1'b1, OFF_STATUS, 32'hFF);
    chk("ro write", er, 32'h1);
  endtask : t_reset
  task automatic t_prog;
    op(32'h5, 32'h3CA5, 32'h065);
    chk("wr status", rd[4:0], 32'h0);
    op(32'h5, 32'h3CA5, 32'h067);
    chk("poll flags", {rd[7], rd[5], rd[1]}, 32'h4);
    chk("poll byte", rd[15:8], 32'hA5);
    op(32'h5, 32'h0, 32'h064);
    apb(1'b0, OFF_RDATA, 32'h0);
    chk("rdata", rd, 32'h3CA5);
    chk("oe clash", clash, 32'h0);
  endtask : t_prog
  task automatic t_fail;
    fail <= 1'b1;
    op(32'h6, 32'h0011, 32'h065);
    op(32'h6, 32'h0011, 32'h067);
    chk("err lock", {rd[3], rd[1]}, 32'h3);
    fail <= 1'b0;
    op(32'h6, 32'h0022, 32'h065);
    chk("refused", rd[4], 32'h1);
    op(32'h6, 32'h00F0, 32'h065);
    chk("unlocked", {rd[4], rd[3]}, 32'h0);
  endtask : t_fail
  task automatic t_page;
    op(32'h10, 32'h0, 32'h066);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, PAGE_BASE + 8'(4 * i), 32'h0);
      chk("page", rd, 32'hA510 + i);
    end
  endtask : t_page
  task automatic t_byte;
    op(32'h0800_0012, 32'h0, 32'h06C);
    chk("byte pin", byte_n, 32'h0);
    apb(1'b0, OFF_RDATA, 32'h0);
    chk("byte hi", rd, 32'hA5);
    op(32'h12, 32'h0, 32'h06C);
    apb(1'b0, OFF_RDATA, 32'h0);
    chk("byte lo", rd, 32'h12);
    apb(1'b1, OFF_CTRL, 32'h060);
  endtask : t_byte
  task automatic t_limits;
    op(32'h0100_0000, 32'h0, 32'h064);
    chk("blk range", rd[4:0], 32'h10);
    op(32'h07FF_0000, 32'h0, 32'h1E4);
    chk("blk 2047", rd[4], 32'h0);
    apb(1'b1, OFF_CTRL, 32'h0);
    op(32'h5, 32'h0, 32'h004);
    chk("rst pin", {rd[4], flash_rst_n, wp_n}, 32'h4);
    apb(1'b1, OFF_CTRL, 32'h060);
  endtask : t_limits
  initial
  begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_prog;
    t_fail;
    t_page;
    t_byte;
    t_limits;
    complete_run;
  end
endmodule : tb
